// ---- verilog/tiopc_trigger_pin.sv ----
// Module: rear-panel trigger pin and output-state indicator pin with AHB-Lite registers
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Setting the indicator invert bit drives the indicator pin at exactly the opposite level.
// - Without inversion the indicator pin is driven low while the instrument output is on.
// - Without inversion the indicator pin is driven high while the instrument output is off.
// - The trigger pin function is chosen among bidirectional trigger (default), level input and driven output.
// - The trigger invert bit flips pulse and level in both directions and is clear by default.
// - In bidirectional trigger function a direction bit picks outgoing or incoming trigger mode.
// - In outgoing mode each internal trigger of measurement, logging or sequence emits one pulse.
// - The outgoing pulse is active low and stays low for at least the minimum width.
// - A manual sequence trigger with manual source starts the run and, in outgoing mode, emits the pulse.
// - In incoming mode an external pulse starts the selected target.
// - An incoming pulse starts a sequence run only while the sequence source is external.
// - In output function a true value drives low, or high when inverted.
// - In output function a false value drives high, or low when inverted.
module tiopc_trigger_pin #(
   parameter int PULSE_CYCLES = tiopc_pkg::PULSE_CYCLES
) (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // Instrument side
   input  wire logic        output_on,
   input  wire logic        int_trig,
   output logic             start_meas,
   output logic             start_dlog,
   output logic             start_seq,
   // Trigger pin
   input  wire logic        trig_pin_i,
   output logic             trig_pin_o,
   output logic             trig_pin_oe_n,
   // Output-state indicator pin
   output logic             ind_pin
);

   // ----------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------
   localparam int CNT_W = 16;
   if (PULSE_CYCLES < 1 || PULSE_CYCLES > 65535)
   begin : g_bad_pulse
      $error("PULSE_CYCLES must lie in 1..65535");
   end

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [tiopc_pkg::CTRL_WIDTH-1:0] ctrl;
   logic [tiopc_pkg::PWM_WIDTH-1:0]  pwm_period;
   logic [tiopc_pkg::PWM_WIDTH-1:0]  pwm_duty;
   logic                             wr_pend;
   logic [7:0]                       wr_addr;
   logic                             manual_req;
   logic                             pin_meta;
   logic                             pin_sync;
   logic                             in_asserted_q;
   logic [CNT_W-1:0]                 pulse_cnt;
   logic                             pulse_active;
   logic                             next_trig_pin_o;
   logic                             next_trig_pin_oe_n;

   tiopc_pwm_if #(.W(tiopc_pkg::PWM_WIDTH)) pwm_bus ();

   // ----------------------------------------------------------------
   // Field decode
   // ----------------------------------------------------------------
   tiopc_pkg::tiopc_func_t   func;
   tiopc_pkg::tiopc_target_t target;
   logic                     ind_inv;
   logic                     trig_inv;
   logic                     dir_in;
   logic                     seq_ext;
   logic                     out_val;
   logic                     out_pwm;

   assign func     = tiopc_pkg::tiopc_func_t'(ctrl[tiopc_pkg::CTRL_FUNC_LO +: 2]);
   assign target   = tiopc_pkg::tiopc_target_t'(ctrl[tiopc_pkg::CTRL_TGT_LO +: 2]);
   assign ind_inv  = ctrl[tiopc_pkg::CTRL_IND_INV];
   assign trig_inv = ctrl[tiopc_pkg::CTRL_TRIG_INV];
   assign dir_in   = ctrl[tiopc_pkg::CTRL_DIR_IN];
   assign seq_ext  = ctrl[tiopc_pkg::CTRL_SEQ_EXT];
   assign out_val  = ctrl[tiopc_pkg::CTRL_OUT_VAL];
   assign out_pwm  = ctrl[tiopc_pkg::CTRL_OUT_PWM];

   logic mode_trig_out;
   logic mode_trig_in;
   logic mode_output;
   assign mode_trig_out = (func == tiopc_pkg::FUNC_TRIG) && !dir_in;
   assign mode_trig_in  = (func == tiopc_pkg::FUNC_TRIG) && dir_in;
   assign mode_output   = (func == tiopc_pkg::FUNC_OUTPUT);

   // ----------------------------------------------------------------
   // Register read function
   // ----------------------------------------------------------------
   function automatic logic [31:0] read_reg(input logic [7:0] addr);
      logic [31:0] d;
      d = 32'h0000_0000;
      if (addr == tiopc_pkg::OFF_CTRL)
      begin
         d[tiopc_pkg::CTRL_WIDTH-1:0] = ctrl;
      end
      else if (addr == tiopc_pkg::OFF_PWM_PERIOD)
      begin
         d[tiopc_pkg::PWM_WIDTH-1:0] = pwm_period;
      end
      else if (addr == tiopc_pkg::OFF_PWM_DUTY)
      begin
         d[tiopc_pkg::PWM_WIDTH-1:0] = pwm_duty;
      end
      else if (addr == tiopc_pkg::OFF_STATUS)
      begin
         // A low pin reads as true, the same sense as a driven true
         d[tiopc_pkg::STAT_IN_LEVEL] = ~pin_sync ^ trig_inv;
         d[tiopc_pkg::STAT_PULSE]    = pulse_active;
         d[tiopc_pkg::STAT_PIN_RAW]  = pin_sync;
         d[tiopc_pkg::STAT_IND_PIN]  = ind_pin;
         d[tiopc_pkg::STAT_PWM_WAVE] = pwm_bus.wave;
      end
      return d;
   endfunction

   // ----------------------------------------------------------------
   // AHB-Lite address phase
   // ----------------------------------------------------------------
   logic addr_ok;
   assign addr_ok = hsel && hready && htrans[1];

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
      end
      else
      begin
         wr_pend <= addr_ok && hwrite && (haddr[31:8] == 24'h000000);
         wr_addr <= haddr[7:0];
      end
   end

   // Zero wait states; every answer is OKAY
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   // Read data is sampled at the address phase; unmapped reads give zero
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         hrdata <= 32'h0000_0000;
      end
      else if (addr_ok && !hwrite)
      begin
         hrdata <= (haddr[31:8] == 24'h000000) ? read_reg(haddr[7:0]) : 32'h0000_0000;
      end
   end

   // ----------------------------------------------------------------
   // Register writes in the data phase
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         ctrl       <= tiopc_pkg::CTRL_RESET;
         pwm_period <= tiopc_pkg::PWM_RESET;
         pwm_duty   <= tiopc_pkg::PWM_RESET;
      end
      else if (wr_pend)
      begin
         if (wr_addr == tiopc_pkg::OFF_CTRL)
         begin
            ctrl <= hwdata[tiopc_pkg::CTRL_WIDTH-1:0];
         end
         else if (wr_addr == tiopc_pkg::OFF_PWM_PERIOD)
         begin
            pwm_period <= hwdata[tiopc_pkg::PWM_WIDTH-1:0];
         end
         else if (wr_addr == tiopc_pkg::OFF_PWM_DUTY)
         begin
            pwm_duty <= hwdata[tiopc_pkg::PWM_WIDTH-1:0];
         end
      end
   end

   // Command strobe: a one-cycle request, never stored
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         manual_req <= 1'b0;
      end
      else
      begin
         manual_req <= wr_pend && (wr_addr == tiopc_pkg::OFF_CMD) && hwdata[tiopc_pkg::CMD_MANUAL];
      end
   end

   // ----------------------------------------------------------------
   // Pin synchroniser and incoming edge
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         pin_meta <= 1'b1;
         pin_sync <= 1'b1;
      end
      else
      begin
         pin_meta <= trig_pin_i;
         pin_sync <= pin_meta;
      end
   end

   logic in_asserted;
   logic in_edge;
   assign in_asserted = pin_sync ^ ~trig_inv;
   assign in_edge     = in_asserted && !in_asserted_q && mode_trig_in;

   // Width of the incoming pulse is the source's duty; only the asserting edge is taken
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         in_asserted_q <= 1'b0;
      end
      else
      begin
         in_asserted_q <= in_asserted;
      end
   end

   // ----------------------------------------------------------------
   // Start pulses to the instrument
   // ----------------------------------------------------------------
   logic manual_go;
   assign manual_go = manual_req && !seq_ext;

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         start_meas <= 1'b0;
         start_dlog <= 1'b0;
         start_seq  <= 1'b0;
      end
      else
      begin
         start_meas <= in_edge && (target == tiopc_pkg::TGT_METER);
         start_dlog <= in_edge && (target == tiopc_pkg::TGT_DLOG);
         start_seq  <= (in_edge && (target == tiopc_pkg::TGT_SEQ) && seq_ext) || manual_go;
      end
   end

   // ----------------------------------------------------------------
   // Outgoing pulse timer
   // ----------------------------------------------------------------
   logic fire;
   assign fire = mode_trig_out && (int_trig || manual_go);

   // A new trigger during a pulse restarts the full low time
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         pulse_cnt    <= '0;
         pulse_active <= 1'b0;
      end
      else if (fire)
      begin
         pulse_cnt    <= CNT_W'(PULSE_CYCLES - 1);
         pulse_active <= 1'b1;
      end
      else if (!mode_trig_out)
      begin
         pulse_cnt    <= '0;
         pulse_active <= 1'b0;
      end
      else if (pulse_cnt != '0)
      begin
         pulse_cnt <= pulse_cnt - CNT_W'(1);
      end
      else
      begin
         pulse_active <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // PWM generator
   // ----------------------------------------------------------------
   assign pwm_bus.enable = mode_output && out_pwm;
   assign pwm_bus.period = pwm_period;
   assign pwm_bus.duty   = pwm_duty;

   tiopc_pwm #(
      .W (tiopc_pkg::PWM_WIDTH)
   ) u_pwm (
      .sys_clk (sys_clk),
      .rst     (rst),
      .pwm     (pwm_bus.gen)
   );

   // ----------------------------------------------------------------
   // Trigger pin drive
   // ----------------------------------------------------------------
   always_comb
   begin
      next_trig_pin_o    = 1'b1;
      next_trig_pin_oe_n = 1'b1;
      if (mode_trig_out)
      begin
         next_trig_pin_o    = ~pulse_active ^ trig_inv;
         next_trig_pin_oe_n = 1'b0;
      end
      else if (mode_output)
      begin
         // True drives low unless inverted
         next_trig_pin_o    = ~(out_pwm ? pwm_bus.wave : out_val) ^ trig_inv;
         next_trig_pin_oe_n = 1'b0;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         trig_pin_o    <= 1'b1;
         trig_pin_oe_n <= 1'b1;
      end
      else
      begin
         trig_pin_o    <= next_trig_pin_o;
         trig_pin_oe_n <= next_trig_pin_oe_n;
      end
   end

   // ----------------------------------------------------------------
   // Output-state indicator pin
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         ind_pin <= 1'b1;
      end
      else
      begin
         ind_pin <= ~output_on ^ ind_inv;
      end
   end

endmodule
`default_nettype wire

// ---- verilog/tiopc_pkg.sv ----
// Package: register map, field layout, reset values and timing for the trigger I/O pin block
package tiopc_pkg;

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFF_CTRL       = 8'h00;
   localparam logic [7:0] OFF_PWM_PERIOD = 8'h04;
   localparam logic [7:0] OFF_PWM_DUTY   = 8'h08;
   localparam logic [7:0] OFF_STATUS     = 8'h0C;
   localparam logic [7:0] OFF_CMD        = 8'h10;

   // ----------------------------------------------------------------
   // Control register fields
   // ----------------------------------------------------------------
   localparam int CTRL_IND_INV  = 0;
   localparam int CTRL_FUNC_LO  = 1;
   localparam int CTRL_TRIG_INV = 3;
   localparam int CTRL_DIR_IN   = 4;
   localparam int CTRL_TGT_LO   = 5;
   localparam int CTRL_SEQ_EXT  = 7;
   localparam int CTRL_OUT_VAL  = 8;
   localparam int CTRL_OUT_PWM  = 9;
   localparam int CTRL_WIDTH    = 10;
   localparam logic [9:0] CTRL_RESET = 10'h000;

   // ----------------------------------------------------------------
   // Status and command fields
   // ----------------------------------------------------------------
   localparam int STAT_IN_LEVEL = 0;
   localparam int STAT_PULSE    = 1;
   localparam int STAT_PIN_RAW  = 2;
   localparam int STAT_IND_PIN  = 3;
   localparam int STAT_PWM_WAVE = 4;
   localparam int CMD_MANUAL    = 0;

   localparam int PWM_WIDTH = 16;
   localparam logic [15:0] PWM_RESET = 16'h0000;

   // ----------------------------------------------------------------
   // Modes
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      FUNC_TRIG   = 2'h0,
      FUNC_INPUT  = 2'h1,
      FUNC_OUTPUT = 2'h2
   } tiopc_func_t;

   typedef enum logic [1:0] {
      TGT_METER = 2'h0,
      TGT_DLOG  = 2'h1,
      TGT_SEQ   = 2'h2
   } tiopc_target_t;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int TRIG_MIN_US  = 30;
   localparam int CLK_FREQ_MHZ = 200;
   // Least time: whole microseconds at an integer MHz rate, so exact
   localparam int PULSE_CYCLES = TRIG_MIN_US * CLK_FREQ_MHZ;

endpackage

// ---- verilog/tiopc_pwm_if.sv ----
// Interface: settings and wave between the pin block and its PWM generator
`timescale 1ns/100ps
`default_nettype none
interface tiopc_pwm_if #(parameter int W = 16);
   logic         enable;
   logic [W-1:0] period;
   logic [W-1:0] duty;
   logic         wave;

   modport ctrl (output enable, output period, output duty, input wave);
   modport gen  (input enable, input period, input duty, output wave);
endinterface
`default_nettype wire

// ---- verilog/tiopc_pwm.sv ----
// Module: square wave generator with period and high time in clock cycles
`timescale 1ns/100ps
`default_nettype none
module tiopc_pwm #(
   parameter int W = 16
) (
   // Clock and reset
   input  wire logic sys_clk,
   input  wire logic rst,
   // Settings and wave
   tiopc_pwm_if.gen  pwm
);

   if (W < 1)
   begin : g_bad_width
      $error("W must be at least 1");
   end

   logic [W-1:0] cnt;

   // ----------------------------------------------------------------
   // Period counter
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (rst || !pwm.enable || cnt >= pwm.period - W'(1))
      begin
         cnt <= '0;
      end
      else
      begin
         cnt <= cnt + W'(1);
      end
   end

   // ----------------------------------------------------------------
   // Wave
   // ----------------------------------------------------------------
   // A zero period holds the wave at false rather than toggling every cycle
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         pwm.wave <= 1'b0;
      end
      else
      begin
         pwm.wave <= pwm.enable && (pwm.period != '0) && (cnt < pwm.duty);
      end
   end

endmodule
`default_nettype wire

// ---- dv/tiopc_trigger_pin_properties.sv ----
// Checker: timing relations on the trigger pin block's ports
`timescale 1ns/100ps
`default_nettype none
module tiopc_trigger_pin_properties #(
   parameter int PULSE_CYCLES = tiopc_pkg::PULSE_CYCLES
) (
   // Clock and reset
   input wire logic        sys_clk,
   input wire logic        rst,
   // Bus
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   // Instrument and pins
   input wire logic        output_on,
   input wire logic        int_trig,
   input wire logic        start_meas,
   input wire logic        start_dlog,
   input wire logic        start_seq,
   input wire logic        trig_pin_i,
   input wire logic        trig_pin_o,
   input wire logic        trig_pin_oe_n,
   input wire logic        ind_pin
);
   logic        ph_wr;
   logic [31:0] ph_a;
   logic [9:0]  sh;
   logic [1:0]  settle;
   logic [15:0] run;
   logic        ctl_wr;
   logic        cmd_go;
   logic        s_ok;
   logic        outg;
   logic        inc;
   logic        act;
   logic        seq_off;

   // ------
   // Shadow of the control register, snooped from writes
   // ------
   assign ctl_wr  = ph_wr && ph_a == 32'h0;
   assign cmd_go  = ph_wr && ph_a == 32'h10 && hwdata[0];
   // Pins lag the register, so judge only once settings have rested
   assign s_ok    = settle == 2'h3;
   assign outg    = s_ok && {sh[4], sh[2:1]} == 3'h0;
   assign inc     = s_ok && {sh[4], sh[2:1]} == 3'h4;
   assign act     = trig_pin_i == sh[3];
   assign seq_off = sh[6:5] == 2'h2 && !sh[7];

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         ph_wr  <= 1'b0;
         sh     <= 10'h000;
         settle <= 2'h0;
      end
      else
      begin
         ph_wr  <= hsel && hready && htrans[1] && hwrite;
         ph_a   <= haddr;
         sh     <= ctl_wr ? hwdata[9:0] : sh;
         settle <= ctl_wr ? 2'h0 : (s_ok ? settle : settle + 2'h1);
      end
   end

   always_ff @(posedge sys_clk)
      run <= (rst || !outg || trig_pin_o != sh[3]) ? 16'h0000 : run + 16'h0001;

   // ------
   // Properties
   // ------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   chk_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus answer not ready or not okay");
   chk_ind_level: assert property (!$past(rst) |-> ind_pin == (!$past(output_on) ^ $past(sh[0])))
      else $error("indicator level wrong");
   chk_pin_enable: assert property (s_ok |-> trig_pin_oe_n == !(outg || sh[2:1] == 2'h2))
      else $error("pin drive enable wrong");
   chk_out_level: assert property (s_ok && sh[2:1] == 2'h2 && !sh[9] |-> trig_pin_o == (!sh[8] ^ sh[3]))
      else $error("output level wrong");
   chk_trig_launch: assert property (outg && int_trig |-> ##[2:3] trig_pin_o == sh[3])
      else $error("outgoing pulse missing");
   chk_pulse_width: assert property (outg && trig_pin_o != sh[3] && run != 16'h0 |-> run >= PULSE_CYCLES)
      else $error("outgoing pulse too short");
   chk_in_start: assert property (inc && $rose(act) && !seq_off
      |-> ##[2:3] {start_meas, start_dlog, start_seq} == (3'h4 >> sh[6:5]))
      else $error("incoming start wrong");
   chk_in_refuse: assert property (inc && $rose(act) && seq_off |-> ##1 !start_seq [*4])
      else $error("sequence started from manual source");
   chk_manual_run: assert property (cmd_go && !sh[7] |-> ##[2:3] start_seq)
      else $error("manual sequence start missing");

   cover property (outg && int_trig);
   cover property (inc && $rose(act));
   cover property (cmd_go && !sh[7]);
endmodule
`default_nettype wire

// ---- dv/tiopc_ext_trigger.sv ----
// Model: external trigger equipment on the rear-panel trigger pin
`timescale 1ns/100ps
`default_nettype none
module tiopc_ext_trigger #(
   parameter int WIDTH = 8
) (
   // Clock
   input  wire logic sys_clk,
   // Requests from the bench
   input  wire logic go,
   input  wire logic act_hi,
   input  wire logic hold,
   input  wire logic level,
   // Pin
   input  wire logic pin,
   output logic      drv_en,
   output logic      drv_lvl,
   // Pulses seen from the device
   output int        width,
   output int        pulses
);
   int left;
   int run;

   // Sends an incoming pulse of the minimum width, never shorter
   always_ff @(posedge sys_clk)
      left <= go ? WIDTH : (left > 0 ? left - 1 : 0);
   assign drv_en  = hold || left > 0;
   assign drv_lvl = left > 0 ? act_hi : level;

   // Measures active pulses while the model leaves the pin undriven
   always_ff @(posedge sys_clk)
   begin
      run <= (!drv_en && pin == act_hi) ? run + 1 : 0;
      if (run > 0 && !(!drv_en && pin == act_hi))
      begin
         width  <= run;
         pulses <= pulses + 1;
      end
   end
endmodule
`default_nettype wire

// ---- dv/tiopc_trigger_pin_test.sv ----
// Testbench: bus, trigger and pin scenarios for the trigger I/O pin block
`timescale 1ns/100ps
`default_nettype none
module tiopc_trigger_pin_test;
   localparam int          PC         = 8;
   localparam logic [31:0] IN_CFG [4] = '{32'h10, 32'hD0, 32'h50, 32'h38};
   localparam logic [2:0]  IN_EXP [4] = '{3'h4, 3'h1, 3'h0, 3'h2};
   logic        sys_clk   = 1'b0;
   logic        rst       = 1'b1;
   logic        hsel      = 1'b0;
   logic        hwrite    = 1'b0;
   logic        output_on = 1'b0;
   logic        int_trig  = 1'b0;
   logic        go        = 1'b0;
   logic        act_hi    = 1'b0;
   logic        hold      = 1'b0;
   logic        level     = 1'b1;
   logic [1:0]  htrans    = 2'h0;
   logic [31:0] haddr     = 32'h0;
   logic [31:0] hwdata    = 32'h0;
   logic [31:0] rd;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        start_meas;
   logic        start_dlog;
   logic        start_seq;
   logic        trig_pin_o;
   logic        trig_pin_oe_n;
   logic        ind_pin;
   logic        drv_en;
   logic        drv_lvl;
   wire logic   trig_pin_i;
   int          width;
   int          pulses;
   int          num_errors = 0;
   int          compares   = 0;
   int          cycles     = 0;
   int          n [3]      = '{0, 0, 0};
   int          e [3]      = '{0, 0, 0};

   always #2.5 sys_clk = ~sys_clk;

   // Pin has a pull-up; the device wins while it drives
   assign trig_pin_i = !trig_pin_oe_n ? trig_pin_o : (drv_en ? drv_lvl : 1'b1);

   tiopc_trigger_pin #(.PULSE_CYCLES(PC)) i_tiopc_trigger_pin (.sys_clk, .rst, .hsel, .haddr, .htrans,
      .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .output_on,
      .int_trig, .start_meas, .start_dlog, .start_seq, .trig_pin_i, .trig_pin_o, .trig_pin_oe_n, .ind_pin);

   tiopc_ext_trigger #(.WIDTH(PC)) i_tiopc_ext_trigger (.sys_clk, .go, .act_hi, .hold, .level,
      .pin(trig_pin_i), .drv_en, .drv_lvl, .width, .pulses);

   // ------
   // Tasks
   // ------
   task automatic close_out();
      $display("errors %0d, compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask

   task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
      @(posedge sys_clk);
      hsel   <= 1'b1;
      haddr  <= a;
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   task automatic ctl(input logic [31:0] v);
      bus(32'h0, 1'b1, v);
      repeat (4) @(posedge sys_clk);
   endtask

   task automatic pulse_out(input logic man);
      int p0;
      p0 = pulses;
      if (man)
         bus(32'h10, 1'b1, 32'h1);
      else
      begin
         @(posedge sys_clk);
         int_trig <= 1'b1;
         @(posedge sys_clk);
         int_trig <= 1'b0;
      end
      repeat (PC + 8) @(posedge sys_clk);
      check("pulse width", width, PC);
      check("pulse count", pulses, p0 + 1);
   endtask

   // Start counters and a ceiling well above the run's length
   always @(posedge sys_clk)
   begin
      cycles <= cycles + 1;
      n[0] <= n[0] + int'(start_meas);
      n[1] <= n[1] + int'(start_dlog);
      n[2] <= n[2] + int'(start_seq);
      if (cycles == 4000)
      begin
         num_errors++;
         close_out();
      end
   end

   // ------
   // Scenarios
   // ------
   initial
   begin
      int p0;
      int lows;
      repeat (5) @(posedge sys_clk);
      rst <= 1'b0;
      bus(32'h0, 1'b0, 32'h0);
      check("ctrl reset", rd, 32'h0);
      check("pin enable", trig_pin_oe_n, 1'b0);
      check("pin idle", trig_pin_o, 1'b1);
      for (int i = 0; i < 4; i++)
      begin
         output_on <= i[0];
         ctl({31'h0, i[1]});
         check("indicator", ind_pin, 1'(~i[0] ^ i[1]));
      end
      for (int v = 0; v < 2; v++)
      begin
         act_hi <= v[0];
         ctl({28'h0, v[0], 3'h0});
         pulse_out(1'b0);
      end
      act_hi <= 1'b0;
      ctl(32'h40);
      pulse_out(1'b1);
      e[2] = 1;
      ctl(32'hC0);
      p0 = pulses;
      bus(32'h10, 1'b1, 32'h1);
      repeat (PC + 8) @(posedge sys_clk);
      check("ignored manual", pulses, p0);
      check("seq starts", n[2], e[2]);
      hold <= 1'b1;
      for (int k = 0; k < 4; k++)
      begin
         act_hi <= IN_CFG[k][3];
         level  <= ~IN_CFG[k][3];
         ctl(IN_CFG[k]);
         @(posedge sys_clk);
         go <= 1'b1;
         @(posedge sys_clk);
         go <= 1'b0;
         repeat (PC + 8) @(posedge sys_clk);
         check("pin released", trig_pin_oe_n, 1'b1);
         for (int j = 0; j < 3; j++)
         begin
            e[j] += IN_EXP[k][2 - j];
            check("start count", n[j], e[j]);
         end
      end
      level <= 1'b0;
      for (int v = 0; v < 2; v++)
      begin
         ctl({28'h0, v[0], 3'h2});
         bus(32'hC, 1'b0, 32'h0);
         check("input status", rd, {31'h0, ~v[0]});
         check("pin released", trig_pin_oe_n, 1'b1);
      end
      hold <= 1'b0;
      for (int v = 0; v < 4; v++)
      begin
         ctl({23'h0, v[0], 4'h0, v[1], 3'h4});
         check("output pin", trig_pin_o, 1'(~(v[0] ^ v[1])));
         check("pin enable", trig_pin_oe_n, 1'b0);
      end
      bus(32'h4, 1'b1, 32'hA);
      bus(32'h8, 1'b1, 32'h3);
      bus(32'h4, 1'b0, 32'h0);
      check("pwm period", rd, 32'hA);
      ctl(32'h204);
      lows = 0;
      repeat (100)
      begin
         @(posedge sys_clk);
         lows += int'(!trig_pin_o);
      end
      check("pwm low cycles", lows, 32'h1E);
      bus(32'h40, 1'b1, 32'h5);
      bus(32'h40, 1'b0, 32'h0);
      check("unmapped", rd, 32'h0);
      bus(32'h10, 1'b0, 32'h0);
      check("command read", rd, 32'h0);
      bus(32'h100, 1'b1, 32'h0);
      bus(32'h4, 1'b1, 32'h0);
      bus(32'h0, 1'b0, 32'h0);
      check("aliased write", rd, 32'h204);
      repeat (4) @(posedge sys_clk);
      check("pwm stopped", trig_pin_o, 1'b1);
      ctl(32'h6);
      check("pin released", trig_pin_oe_n, 1'b1);
      close_out();
   end
endmodule

bind tiopc_trigger_pin tiopc_trigger_pin_properties #(.PULSE_CYCLES(PULSE_CYCLES)) i_props (.sys_clk, .rst,
   .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp, .output_on, .int_trig,
   .start_meas, .start_dlog, .start_seq, .trig_pin_i, .trig_pin_o, .trig_pin_oe_n, .ind_pin);
`default_nettype wire
